// *** inc/pmh_pkg.sv ***
`default_nettype none
package pmh_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_EVEN = 8'h10;
  localparam logic [7:0] OFF_CODES = 8'h14;
  // command codes, defaults only
  localparam logic [7:0] ENABLE_CODE_RST = 8'hA0;
  localparam logic [7:0] DISABLE_CODE_RST = 8'hA1;
  // control register fields
  localparam int FLAG_BIT = 0;
  localparam int SLP_GO_BIT = 1;
  localparam int SLEEP_TYPE_FIELD_LSB = 2;
  localparam int SLEEP_TYPE_FIELD_W = 3;
  localparam logic [2:0] SLEEP_TYPE_FIELD_SOFT_OFF = 3'h5;
  // event enable and interrupt fields
  localparam int EVENT_W = 8;
  localparam int ST_SWITCHED = 0;
  localparam int ST_SLEEP = 1;
  localparam int ST_BADCMD = 2;
  localparam int ST_W = 3;
  // reconfiguration delay in cycles
  localparam logic [3:0] RECONF_CYCLES = 4'h4;
  // address regions
  localparam logic [31:0] FB_BASE = 32'h000A0000;
  localparam logic [31:0] FB_TOP = 32'h000BFFFF;
  localparam logic [31:0] AROM_BASE = 32'h000C0000;
  localparam logic [31:0] AROM_TOP = 32'h000DFFFF;
  localparam logic [31:0] FWROM_BASE = 32'h000E0000;
  localparam logic [31:0] FWROM_TOP = 32'h000FFFFF;
  localparam logic [31:0] CRAM_BASE = 32'h00100000;
  localparam logic [31:0] CRAM_TOP = 32'h007FFFFF;
  localparam logic [31:0] BOOT_BASE_RST = 32'hFFF00000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    DST_RAM = 3'h0,
    DST_FB = 3'h1,
    DST_AROM = 3'h2,
    DST_FWROM = 3'h3,
    DST_BOOT = 3'h4,
    DST_MMIO = 3'h5
  } pmh_dest_type;

  typedef struct packed {
    logic [31:0] addr;
    logic mmio_req;
  } pmh_dec_req_type;

  typedef struct packed {
    pmh_dest_type dest;
    logic mmio_blocked;
  } pmh_dec_resp_type;

  typedef enum logic [1:0] {
    MS_LEGACY = 2'b00,
    MS_ENTERING = 2'b01,
    MS_MANAGED = 2'b10,
    MS_LEAVING = 2'b11
  } pmh_mode_type;
endpackage
`default_nettype wire

// *** hdl/pmh_decoder.sv ***
`default_nettype none
module pmh_decoder (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [31:0] boot_base, // start of boot rom region
  input wire pmh_pkg::pmh_dec_req_type req, // address to decode
  output pmh_pkg::pmh_dec_resp_type resp // registered destination
);
  import pmh_pkg::*;

  function automatic logic in_rng(input logic [31:0] a,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  pmh_dec_resp_type next_resp;

  // first match wins; boot region checked first as it reaches the top
  always_comb begin
    next_resp.mmio_blocked = 1'b0;
    if (req.addr >= boot_base) begin
      next_resp.dest = DST_BOOT;
    end else if (in_rng(req.addr, FB_BASE, FB_TOP)) begin
      next_resp.dest = DST_FB;
    end else if (in_rng(req.addr, AROM_BASE, AROM_TOP)) begin
      next_resp.dest = DST_AROM;
    end else if (in_rng(req.addr, FWROM_BASE, FWROM_TOP)) begin
      next_resp.dest = DST_FWROM;
    end else if (in_rng(req.addr, CRAM_BASE, CRAM_TOP)) begin
      // contiguous ram never carries i/o, requests fall back to ram
      next_resp.dest = DST_RAM;
      next_resp.mmio_blocked = req.mmio_req;
    end else if (req.mmio_req && req.addr > CRAM_TOP) begin
      next_resp.dest = DST_MMIO;
    end else begin
      next_resp.dest = DST_RAM;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp <= '{dest: DST_RAM, mmio_blocked: 1'b0};
    end else begin
      resp <= next_resp;
    end
  end

  AST_CRAM_NO_MMIO: assert property (@(posedge aclk) disable iff (!aresetn)
    resp.dest == DST_MMIO |-> $past(req.addr) > CRAM_TOP)
    else $error("mmio decoded inside contiguous ram");
  AST_BOOT_TOP: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && $past(req.addr) >= $past(boot_base)
    |-> resp.dest == DST_BOOT)
    else $error("boot region not decoded to boot rom");
  AST_FB_HOLE: assert property (@(posedge aclk) disable iff (!aresetn)
    (req.addr >= FB_BASE && req.addr <= FB_TOP && req.addr < boot_base)
    |=> resp.dest == DST_FB)
    else $error("frame buffer hole misdecoded");
endmodule
`default_nettype wire

// *** hdl/pmh_top.sv ***
`default_nettype none
module pmh_top (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [pmh_pkg::EVENT_W-1:0] event_src, // raw event levels
  output logic [pmh_pkg::EVENT_W-1:0] legacy_event, // events to legacy path
  output logic power_event_irq, // power event interrupt, level
  output logic soft_off, // soft-off entry, held
  output logic sleep_req, // other sleep entry pulse
  output logic [2:0] sleep_type_out, // type for sleep_req
  input wire pmh_pkg::pmh_dec_req_type dec_req, // address to decode
  output pmh_pkg::pmh_dec_resp_type dec_resp, // decoded destination
  output logic irq // block interrupt, level
);
  import pmh_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // state
  pmh_mode_type mode, next_mode;
  logic [3:0] reconf_cnt, next_reconf_cnt;
  logic managed_mode_flag, next_managed_mode_flag;
  logic [2:0] sleep_type_field, next_sleep_type_field;
  logic [EVENT_W-1:0] general_event_enable, next_general_event_enable;
  logic [7:0] mode_enable_code, next_mode_enable_code;
  logic [7:0] mode_disable_code, next_mode_disable_code;
  logic [31:0] boot_base, next_boot_base;
  logic [ST_W-1:0] status, next_status, mask, next_mask;
  logic soft_off_q, next_soft_off;
  logic sleep_req_q, next_sleep_req;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr_q, next_aw_addr_q;
  logic [31:0] w_data_q, next_w_data_q;
  logic [3:0] w_strb_q, next_w_strb_q;
  logic bvalid_q, next_bvalid;
  logic [1:0] bresp_q, next_bresp;
  logic rvalid_q, next_rvalid;
  logic [31:0] rdata_q, next_rdata;
  logic [1:0] rresp_q, next_rresp;

  logic wr_fire, cmd_wr, cmd_en, cmd_dis, ctrl_wr, slp_go;
  logic [2:0] wr_typ;
  logic [ST_W-1:0] ev;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_CMD) || (a == OFF_CTRL) || (a == OFF_STAT) ||
             (a == OFF_MASK) || (a == OFF_EVEN) || (a == OFF_CODES);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes: accept each channel once, answer when both held
  assign awready = !aw_held && !bvalid_q;
  assign wready = !w_held && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign wr_fire = aw_held && w_held && !bvalid_q;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr_q = aw_addr_q;
    next_w_data_q = w_data_q;
    next_w_strb_q = w_strb_q;
    next_bvalid = bvalid_q;
    next_bresp = bresp_q;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr_q = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data_q = wdata;
      next_w_strb_q = wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      next_bvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write decode; the command port looks only at the low byte lane
  assign cmd_wr = wr_fire && aw_addr_q == OFF_CMD && w_strb_q[0];
  assign cmd_en = cmd_wr && w_data_q[7:0] == mode_enable_code;
  assign cmd_dis = cmd_wr && w_data_q[7:0] == mode_disable_code;
  assign ctrl_wr = wr_fire && aw_addr_q == OFF_CTRL && w_strb_q[0];
  assign wr_typ = w_data_q[SLEEP_TYPE_FIELD_LSB +: SLEEP_TYPE_FIELD_W];
  // type is stored by the same write that sets go, so type-then-go holds
  assign slp_go = ctrl_wr && w_data_q[SLP_GO_BIT];

  ////////////////////////////////////////////////////////////////////
  // mode handover machine
  always_comb begin
    next_mode = mode;
    next_reconf_cnt = reconf_cnt;
    next_managed_mode_flag = managed_mode_flag;
    unique case (mode)
      MS_LEGACY: begin
        if (cmd_en) begin
          next_mode = MS_ENTERING;
          next_reconf_cnt = RECONF_CYCLES;
        end
      end
      MS_ENTERING: begin
        // flag only after reconfiguration has settled
        if (reconf_cnt == 4'h0) begin
          next_mode = MS_MANAGED;
          next_managed_mode_flag = 1'b1;
        end else begin
          next_reconf_cnt = reconf_cnt - 4'h1;
        end
      end
      MS_MANAGED: begin
        if (cmd_dis) begin
          next_mode = MS_LEAVING;
        end
      end
      MS_LEAVING: begin
        // routing already legacy in this state; flag drops one cycle later
        next_mode = MS_LEGACY;
        next_managed_mode_flag = 1'b0;
      end
    endcase
  end

  // events go to legacy handling unless fully managed
  assign legacy_event = (mode == MS_MANAGED) ? '0 : event_src;
  // gated by flag and by software-armed enables
  assign power_event_irq = managed_mode_flag && mode == MS_MANAGED &&
                           |(event_src & general_event_enable);

  ////////////////////////////////////////////////////////////////////
  // configuration, sleep control and interrupt status
  always_comb begin
    next_sleep_type_field = sleep_type_field;
    next_general_event_enable = general_event_enable;
    next_mode_enable_code = mode_enable_code;
    next_mode_disable_code = mode_disable_code;
    next_boot_base = boot_base;
    next_mask = mask;
    next_soft_off = soft_off_q;
    next_sleep_req = 1'b0;
    if (ctrl_wr) begin
      next_sleep_type_field = wr_typ;
    end
    if (slp_go && wr_typ == SLEEP_TYPE_FIELD_SOFT_OFF) begin
      next_soft_off = 1'b1;
    end else if (slp_go) begin
      next_sleep_req = 1'b1;
    end
    if (wr_fire && aw_addr_q == OFF_EVEN && w_strb_q[0]) begin
      next_general_event_enable = w_data_q[EVENT_W-1:0];
    end
    // disarm on the way in and out: enables armed before the switch
    // would otherwise fire the interrupt the moment the flag rises
    if (mode == MS_LEAVING || mode == MS_ENTERING) begin
      next_general_event_enable = '0;
    end
    if (wr_fire && aw_addr_q == OFF_CODES) begin
      if (w_strb_q[0]) next_mode_enable_code = w_data_q[7:0];
      if (w_strb_q[1]) next_mode_disable_code = w_data_q[15:8];
    end
    if (wr_fire && aw_addr_q == OFF_MASK && w_strb_q[0]) begin
      next_mask = w_data_q[ST_W-1:0];
    end
  end

  // events: flag change, sleep request, unknown command byte
  always_comb begin
    ev = '0;
    ev[ST_SWITCHED] = managed_mode_flag != next_managed_mode_flag;
    ev[ST_SLEEP] = slp_go;
    ev[ST_BADCMD] = cmd_wr && !cmd_en && !cmd_dis;
    next_status = status;
    if (wr_fire && aw_addr_q == OFF_STAT && w_strb_q[0]) begin
      next_status = status & ~w_data_q[ST_W-1:0];
    end
    // set wins over a clear in the same cycle
    next_status = next_status | ev;
  end
  assign irq = |(status & mask);
  assign soft_off = soft_off_q;
  assign sleep_req = sleep_req_q;
  assign sleep_type_out = sleep_type_field;

  ////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    next_rvalid = rvalid_q;
    next_rdata = rdata_q;
    next_rresp = rresp_q;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (araddr)
        OFF_CTRL: next_rdata = {27'h0, sleep_type_field, 1'b0,
                                managed_mode_flag};
        OFF_STAT: next_rdata = {29'h0, status};
        OFF_MASK: next_rdata = {29'h0, mask};
        OFF_EVEN: next_rdata = {24'h0, general_event_enable};
        OFF_CODES: next_rdata = {16'h0, mode_disable_code,
                                 mode_enable_code};
        default: next_rdata = 32'h00000000;
      endcase
    end else if (rvalid_q && rready) begin
      next_rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MS_LEGACY;
      reconf_cnt <= 4'h0;
      managed_mode_flag <= 1'b0;
      sleep_type_field <= 3'h0;
      general_event_enable <= '0;
      mode_enable_code <= ENABLE_CODE_RST;
      mode_disable_code <= DISABLE_CODE_RST;
      boot_base <= BOOT_BASE_RST;
      status <= '0;
      mask <= '0;
      soft_off_q <= 1'b0;
      sleep_req_q <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      mode <= next_mode;
      reconf_cnt <= next_reconf_cnt;
      managed_mode_flag <= next_managed_mode_flag;
      sleep_type_field <= next_sleep_type_field;
      general_event_enable <= next_general_event_enable;
      mode_enable_code <= next_mode_enable_code;
      mode_disable_code <= next_mode_disable_code;
      boot_base <= next_boot_base;
      status <= next_status;
      mask <= next_mask;
      soft_off_q <= next_soft_off;
      sleep_req_q <= next_sleep_req;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr_q <= next_aw_addr_q;
      w_data_q <= next_w_data_q;
      w_strb_q <= next_w_strb_q;
      bvalid_q <= next_bvalid;
      bresp_q <= next_bresp;
      rvalid_q <= next_rvalid;
      rdata_q <= next_rdata;
      rresp_q <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // address decoder
  pmh_decoder u_dec (
    .aclk(aclk),
    .aresetn(aresetn),
    .boot_base(boot_base),
    .req(dec_req),
    .resp(dec_resp)
  );

  ////////////////////////////////////////////////////////////////////
  // checks
  AST_FLAG_AFTER_RECONF: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (mode == MS_LEGACY && cmd_en) |=> !managed_mode_flag [*5]
    ##1 managed_mode_flag)
    else $error("mode flag not set after reconfiguration");
  AST_NO_IRQ_UNARMED: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (!managed_mode_flag || general_event_enable == '0)
    |-> !power_event_irq)
    else $error("power event interrupt while unarmed");
  AST_NO_IRQ_AT_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(managed_mode_flag) |-> !power_event_irq)
    else $error("power event interrupt as the flag rises");
  AST_DISABLE_SEQ: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MS_MANAGED && cmd_dis) |=> legacy_event == event_src
    && managed_mode_flag ##1 !managed_mode_flag)
    else $error("disable sequence out of order");
  AST_SOFT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (slp_go && wr_typ == SLEEP_TYPE_FIELD_SOFT_OFF) |=> soft_off)
    else $error("soft-off not entered");
  AST_TYPE_KEPT: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_wr |=> sleep_type_out == $past(wr_typ))
    else $error("sleep type not stored");
  AST_BAD_CODE: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_wr && !cmd_en && !cmd_dis &&
     (mode == MS_LEGACY || mode == MS_MANAGED)) |=> $stable(mode))
    else $error("unknown code changed mode");
endmodule
`default_nettype wire

// *** tb/pmh_top_test.sv ***
`default_nettype none
module pmh_top_test import pmh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic power_event_irq, soft_off, sleep_req, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [EVENT_W-1:0] event_src, legacy_event;
  logic [2:0] sleep_type_out;
  pmh_dec_req_type dec_req;
  pmh_dec_resp_type dec_resp;
  int n_errors = 0;
  int check_count = 0;
  int n_sleep = 0;

  ////////////////////////////////////////////////////////////////////////
  pmh_top uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .event_src(event_src), .legacy_event(legacy_event),
    .power_event_irq(power_event_irq), .soft_off(soft_off),
    .sleep_req(sleep_req), .sleep_type_out(sleep_type_out),
    .dec_req(dec_req), .dec_resp(dec_resp), .irq(irq)
  );

  // 50 MHz clock
  always #10 aclk = ~aclk;

  // count one-cycle sleep pulses, so a held pulse shows up as extra
  always @(posedge aclk) begin
    if (sleep_req === 1'b1) n_sleep <= n_sleep + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // a wait that runs out ends the run
  task automatic hang(input string what);
    n_errors++;
    $display("ERROR t=%0t no answer on %s", $time, what);
    conclude();
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (aw_ok && w_ok && bvalid) break;
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    if (n == 50) hang("write");
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic ar_ok;
    ar_ok = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (ar_ok && rvalid) break;
      if (arvalid && arready) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
    end
    if (n == 50) hang("read");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // poll the mode flag; interrupt must stay quiet while enables are zero
  task automatic wait_flag(input logic want);
    int n;
    for (n = 0; n < 30; n++) begin
      axi_rd(OFF_CTRL, rd, rsp);
      chk(power_event_irq, 0, "event irq with enables off");
      if (rd[FLAG_BIT] === want) break;
    end
    if (n == 30) hang("mode flag");
  endtask

  task automatic dec(input logic [31:0] a, input logic m,
                     input pmh_dest_type exp, input logic blk);
    @(posedge aclk);
    dec_req <= '{addr: a, mmio_req: m};
    @(posedge aclk);
    @(posedge aclk);
    chk(dec_resp.dest, exp, "decode destination");
    chk(dec_resp.mmio_blocked, blk, "decode mmio block");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(irq, 0, "irq at reset");
    chk(soft_off, 0, "soft_off at reset");
    axi_rd(OFF_CODES, rd, rsp);
    chk(rd, {16'h0, DISABLE_CODE_RST, ENABLE_CODE_RST}, "codes reset");
    axi_rd(OFF_CTRL, rd, rsp);
    chk(rd[FLAG_BIT], 0, "flag at reset");
  endtask

  // stray command byte: no switch, but status and masked interrupt
  task automatic t_badcmd;
    // moved codes: the old enable byte must now count as stray
    axi_wr(OFF_CODES, 32'h0000C3B2, rsp);
    axi_wr(OFF_CMD, 32'(ENABLE_CODE_RST), rsp);
    axi_wr(OFF_CMD, 32'h55, rsp);
    repeat (8) @(posedge aclk);
    axi_rd(OFF_CTRL, rd, rsp);
    chk(rd[FLAG_BIT], 0, "flag after stray byte");
    chk(legacy_event, event_src, "legacy routing kept");
    axi_rd(OFF_STAT, rd, rsp);
    chk(rd[ST_BADCMD], 1, "stray byte status");
    chk(irq, 0, "irq while masked");
    axi_wr(OFF_MASK, 32'h1 << ST_BADCMD, rsp);
    chk(irq, 1, "irq unmasked");
    axi_wr(OFF_STAT, 32'h1 << ST_BADCMD, rsp);
    chk(irq, 0, "irq after clear");
    axi_wr(OFF_MASK, 32'h0, rsp);
    axi_wr(OFF_CODES, {16'h0, DISABLE_CODE_RST, ENABLE_CODE_RST}, rsp);
  endtask

  // enables armed in legacy mode must not fire the irq at the switch
  task automatic t_enable;
    axi_wr(OFF_EVEN, 32'h04, rsp);
    axi_wr(OFF_CMD, 32'(ENABLE_CODE_RST), rsp);
    wait_flag(1'b1);
    chk(power_event_irq, 0, "event irq right after set");
    chk(legacy_event, 0, "managed routing");
    axi_wr(OFF_CMD, 32'h5A, rsp);
    axi_rd(OFF_CTRL, rd, rsp);
    chk(rd[FLAG_BIT], 1, "flag kept on stray byte");
    axi_wr(OFF_EVEN, 32'h04, rsp);
    chk(power_event_irq, 1, "event irq once enabled");
    event_src <= 8'hFB;
    @(posedge aclk);
    @(posedge aclk);
    chk(power_event_irq, 0, "event irq on disabled source");
    event_src <= 8'hFF;
    axi_wr(OFF_MASK, 32'h1 << ST_SWITCHED, rsp);
    chk(irq, 1, "switch status irq");
    axi_wr(OFF_STAT, 32'h1 << ST_SWITCHED, rsp);
    chk(irq, 0, "switch status cleared");
    axi_wr(OFF_MASK, 32'h0, rsp);
  endtask

  task automatic t_disable;
    axi_wr(OFF_EVEN, 32'h0, rsp);
    axi_wr(OFF_CMD, 32'(DISABLE_CODE_RST), rsp);
    @(posedge aclk);
    chk(legacy_event, 8'hFF, "rerouted to legacy");
    wait_flag(1'b0);
    chk(legacy_event, 8'hFF, "legacy after flag clear");
  endtask

  // light sleep pulses once; soft-off type then go latches soft_off
  task automatic t_sleep;
    axi_wr(OFF_CTRL, 32'h0E, rsp);
    @(posedge aclk);
    chk(sleep_type_out, 3'h3, "sleep type out");
    chk(n_sleep, 1, "one sleep pulse");
    chk(soft_off, 0, "no soft-off on light type");
    axi_rd(OFF_STAT, rd, rsp);
    chk(rd[ST_SLEEP], 1, "sleep go status");
    // resume from light sleep: no new enable code, mode still managed
    axi_rd(OFF_CTRL, rd, rsp);
    chk(rd[FLAG_BIT], 1, "still managed after light sleep");
    axi_wr(OFF_CTRL, 32'(SLEEP_TYPE_FIELD_SOFT_OFF) << SLEEP_TYPE_FIELD_LSB, rsp);
    axi_wr(OFF_CTRL, (32'(SLEEP_TYPE_FIELD_SOFT_OFF) << SLEEP_TYPE_FIELD_LSB) | 32'h2,
           rsp);
    @(posedge aclk);
    chk(soft_off, 1, "soft-off entered");
    chk(n_sleep, 1, "no pulse on soft-off");
    axi_rd(OFF_CTRL, rd, rsp);
    chk(rd[4:1], {SLEEP_TYPE_FIELD_SOFT_OFF, 1'b0}, "type kept, go reads 0");
  endtask

  task automatic t_decode;
    dec(32'h000A0000, 1'b0, DST_FB, 1'b0);
    dec(32'h000BFFFF, 1'b0, DST_FB, 1'b0);
    dec(32'h000C0000, 1'b0, DST_AROM, 1'b0);
    dec(32'h000DFFFF, 1'b0, DST_AROM, 1'b0);
    dec(32'h000E0000, 1'b0, DST_FWROM, 1'b0);
    dec(32'h000FFFFF, 1'b0, DST_FWROM, 1'b0);
    dec(32'h00100000, 1'b1, DST_RAM, 1'b1);
    dec(32'h007FFFFF, 1'b1, DST_RAM, 1'b1);
    dec(32'h00800000, 1'b1, DST_MMIO, 1'b0);
    dec(32'hFFF00000, 1'b0, DST_BOOT, 1'b0);
    dec(32'hFFFFFFFF, 1'b0, DST_BOOT, 1'b0);
    dec(32'hFFEFFFFF, 1'b0, DST_RAM, 1'b0);
  endtask

  task automatic t_unmapped;
    axi_rd(8'h40, rd, rsp);
    chk(rsp, RESP_SLVERR, "unmapped read");
    axi_wr(8'h40, 32'h1, rsp);
    chk(rsp, RESP_SLVERR, "unmapped write");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // reset held two cycles, all inputs defined from time zero
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    event_src = 8'hFF;
    dec_req = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_unmapped();
    t_badcmd();
    t_enable();
    t_disable();
    t_decode();
    t_enable();
    t_sleep();
    conclude();
  end
endmodule
`default_nettype wire
